// [cbs_map.svh]
// register map, field positions, reset values and timing counts for the supervisor
`ifndef CBS_MAP_SVH
`define CBS_MAP_SVH
`define CBS_CLK_HZ 40000000
`define CBS_OVL_TIME_MS 30
`define CBS_OVL_CYC (`CBS_OVL_TIME_MS * (`CBS_CLK_HZ / 1000))
`define CBS_PULSE_TIME_US 128
`define CBS_PULSE_CYC (`CBS_PULSE_TIME_US * (`CBS_CLK_HZ / 1000000))
`define CBS_HOST_TIME_S 32
`define CBS_HOST_CYC (`CBS_HOST_TIME_S * `CBS_CLK_HZ)
`define CBS_A_CTRL 8'h00
`define CBS_A_STATE 8'h04
`define CBS_A_FAULT 8'h08
`define CBS_A_IRQ_STAT 8'h0C
`define CBS_A_IRQ_MASK 8'h10
`define CBS_CTRL_OPSEL 0
`define CBS_CTRL_HIZ 1
`define CBS_CTRL_CHGDIS 2
`define CBS_CTRL_STATEN 3
`define CBS_CTRL_RST 4'h0
`define CBS_FLT_OVL 0
`define CBS_FLT_BATHI 1
`define CBS_FLT_BATLO 2
`define CBS_FLT_CHG 3
`define CBS_IRQ_BOOSTF 0
`define CBS_IRQ_CHGF 1
`define CBS_IRQ_TMR 2
`define CBS_IRQ_STATE 3
`endif

// [cbs_pkg.sv]
// types shared by the supervisor modules
package cbs_pkg;
	typedef enum logic [2:0] {
		ST_PWR_DOWN,
		ST_CHG_CFG,
		ST_SHORT_CHG,
		ST_PWM_CHG,
		ST_HIZ,
		ST_BOOST
	} cbs_state_t;
	// synchronised comparator flags and the boost request pin
	typedef struct packed {
		logic boost_req_pin;
		logic vbus_above_lockout;
		logic vbus_above_min;
		logic rail_above_short;
		logic bat_above_max;
		logic bat_below_min;
		logic bat_below_low;
		logic overload;
		logic charge_fault;
	} cbs_cmp_t;
	// power stage enables
	typedef struct packed {
		logic serial_on;
		logic buck_on;
		logic short_src_on;
		logic boost_on;
		logic input_blocking_switch_on;
	} cbs_pwr_t;
endpackage

// [cbs_pulse.sv]
// fixed-width fault pulse generator for the status pin
`timescale 1ns/1ps
`default_nettype none
module cbs_pulse #(
	parameter logic [31:0] CYC = 32'd5120
) (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_trig,
	output logic o_busy
);
	logic [31:0] cnt_r;
	wire last = (cnt_r == CYC - 32'd1);
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			cnt_r <= '0;
			o_busy <= 1'b0;
		end else if (o_busy) begin
			cnt_r <= last ? 32'd0 : cnt_r + 32'd1; // RULE19
			o_busy <= !last; // RULE7
		end else if (i_trig) begin
			o_busy <= 1'b1; // RULE7
		end
	end
	AST_PULSE_START: assert property (@(posedge i_clk) disable iff (!i_resetn) // RULE7
		(i_trig && !o_busy) |=> (o_busy && cnt_r == 32'd0))
		else $error("fault pulse did not start");
	AST_PULSE_END: assert property (@(posedge i_clk) disable iff (!i_resetn) // RULE7
		(o_busy && cnt_r == CYC - 32'd1) |=> !o_busy)
		else $error("fault pulse wrong length");
endmodule // cbs_pulse
`default_nettype wire

// [cbs_stat_host.sv]
// host side of the open-drain status pin: pull-up level, pulse count and last low width
`timescale 1ns/1ps
`default_nettype none
module cbs_stat_host (
	// pin drive from the supervisor
	input wire logic i_clk,
	input wire logic i_stat_o,
	input wire logic i_stat_oe,
	// observed pin and pulse figures
	output logic o_pin,
	output var int o_cnt,
	output var int o_width
);
	int run;
	// a released pin floats high through the pull-up
	assign o_pin = i_stat_oe ? i_stat_o : 1'b1;
	initial begin
		o_cnt = 0;
		o_width = 0;
		run = 0;
	end
	always @(posedge i_clk) begin
		if (o_pin === 1'b0) begin
			run = run + 1;
			if (run == 1)
				o_cnt = o_cnt + 1;
		end else if (run != 0) begin
			o_width = run;
			run = 0;
		end
	end
endmodule // cbs_stat_host
`default_nettype wire

// [cbs_sync.sv]
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module cbs_sync #(
	parameter int W = 1
) (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	logic [W-1:0] q_nxt;
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			assign q_nxt[g] = (s2_r[g] == s3_r[g]) ? s3_r[g] : o_q[g];
		end
	endgenerate
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			o_q <= '0;
		end else begin
			s1_r <= i_d;
			s2_r <= s1_r;
			s3_r <= s2_r;
			o_q <= q_nxt; // RULE18
		end
	end
	AST_SYNC_AGREE: assert property (@(posedge i_clk) disable iff (!i_resetn) // RULE18
		(o_q != $past(o_q)) |-> ($past(s2_r) == $past(s3_r)))
		else $error("synchroniser output changed without agreement");
endmodule // cbs_sync
`default_nettype wire

// [cbs_top.sv]
// mode and fault supervisor for a one-cell charger with boost output
// What this block does
// [RULE1] overload fault only after overload held over 30 ms while boosting
// [RULE2] overload fault stops converter, clears operation select, sets fault bits, pulses status
// [RULE3] no boost restart after overload until host clears fault register
// [RULE4] battery over or under threshold in boost causes same fault actions
// [RULE5] after battery fault, boost resumes on operation select write or held request pin
// [RULE6] fault-free boosting leaves status pin released
// [RULE7] each boost fault drives status low for one 128 us pulse; a fault that arrives while a pulse is still running starts no pulse of its own
// [RULE8] high-impedance bit with request pin idle enters high-impedance mode
// [RULE9] crude 32 s host timer runs in high impedance with battery low
// [RULE10] timer expiry enters 32 minute mode and stops the timer
// [RULE11] in 32 minute mode, input below lockout forces high impedance
// [RULE12] power-down left on input or rail good; exit issues reset; all off
// [RULE13] charge-configure keeps converters off; exits on select, hiz, lockout, request
// [RULE14] short charge when charge allowed and rail below short; current source only
// [RULE15] PWM charge runs buck; left on any charge-disallowing condition
// [RULE16] boost requested by pin or select bit while high-impedance bit is 0
// [RULE17] charging with status enable holds status low, otherwise released
// [RULE18] comparator flags and request pin synchronised before use
// [RULE19] pulse, overload and host timers are parameterised system-clock counters
`timescale 1ns/1ps
`default_nettype none
`include "cbs_map.svh"
module cbs_top
	import cbs_pkg::*;
#(
	parameter logic [31:0] OVL_CYC = 32'(`CBS_OVL_CYC),
	parameter logic [31:0] PULSE_CYC = 32'(`CBS_PULSE_CYC),
	parameter logic [31:0] HOST_CYC = 32'(`CBS_HOST_CYC)
) (
	// clock and reset
	input wire logic I_CLK,
	input wire logic I_RESETN,
	// register port
	input wire logic [7:0] I_ADDR,
	input wire logic [31:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	output logic [31:0] O_RDATA,
	// comparators and request pin, asynchronous
	input wire cbs_cmp_t I_CMP,
	// power stage enables and reset request
	output cbs_pwr_t O_PWR,
	output logic O_POR,
	// open-drain status pin
	output logic O_STAT_O,
	output logic O_STAT_OE,
	// interrupt
	output logic O_IRQ
);
	cbs_cmp_t c;
	cbs_state_t state_r;
	cbs_state_t state_nxt;
	logic [3:0] ctrl_r;
	logic [3:0] fault_r;
	logic [3:0] irq_stat_r;
	logic [3:0] irq_mask_r;
	logic [31:0] ovl_cnt_r;
	logic [31:0] host_cnt_r;
	logic auto32_r;
	logic ovl_lock_r;
	logic chg_fault_d_r;
	logic pulse_busy;

	cbs_sync #(
		.W($bits(cbs_cmp_t))
	) u_sync (
		.i_clk(I_CLK),
		.i_resetn(I_RESETN),
		.i_d(I_CMP),
		.o_q(c) // RULE18
	);

	// register decode
	wire wr_ctrl = I_WR && (I_ADDR == `CBS_A_CTRL);
	wire wr_fault = I_WR && (I_ADDR == `CBS_A_FAULT);
	wire wr_mask = I_WR && (I_ADDR == `CBS_A_IRQ_MASK);
	wire rd_irq = I_RD && (I_ADDR == `CBS_A_IRQ_STAT);
	wire op_sel = ctrl_r[`CBS_CTRL_OPSEL];
	wire hiz_bit = ctrl_r[`CBS_CTRL_HIZ];
	wire chg_dis = ctrl_r[`CBS_CTRL_CHGDIS];
	wire stat_en = ctrl_r[`CBS_CTRL_STATEN];
	wire boost_request_pin = c.boost_req_pin;

	// mode request terms
	wire boosting = (state_r == ST_BOOST);
	wire bat_hi = boosting && c.bat_above_max;
	wire bat_lo = boosting && c.bat_below_min;
	wire bat_flt = bat_hi || bat_lo; // RULE4
	wire ovl_flt = boosting && c.overload && (ovl_cnt_r == OVL_CYC); // RULE1
	wire boost_flt = ovl_flt || bat_flt;
	wire bat_ok = !c.bat_above_max && !c.bat_below_min;
	wire hiz_req = (hiz_bit && !boost_request_pin) || (auto32_r && !c.vbus_above_lockout); // RULE8 RULE11
	wire boost_req = (boost_request_pin || op_sel) && !hiz_bit; // RULE16
	wire boost_ok = boost_req && !ovl_lock_r && bat_ok; // RULE3 RULE5
	wire chg_ok = !op_sel && !hiz_bit && !boost_request_pin && c.vbus_above_min && !chg_dis && !c.charge_fault;
	wire charging = (state_r == ST_SHORT_CHG) || (state_r == ST_PWM_CHG);
	wire host_run = (state_r == ST_HIZ) && c.bat_below_low && !auto32_r; // RULE9
	wire host_exp = host_run && (host_cnt_r == HOST_CYC - 32'd1);
	wire chg_flt_rise = c.charge_fault && !chg_fault_d_r;
	wire pd_exit = (state_r == ST_PWR_DOWN) && (state_nxt != ST_PWR_DOWN);

	// next mode from a powered state
	function automatic cbs_state_t run_mode(input logic hz, input logic bst, input logic flt,
		input logic chg, input logic short_ok, input logic lock_ok, input logic rail);
		if (!lock_ok && !rail)
			run_mode = ST_PWR_DOWN;
		else if (hz || !lock_ok)
			run_mode = ST_HIZ;
		else if (bst && !flt)
			run_mode = ST_BOOST;
		else if (chg)
			run_mode = short_ok ? ST_PWM_CHG : ST_SHORT_CHG;
		else
			run_mode = ST_CHG_CFG;
	endfunction

	// enables for each mode
	function automatic cbs_pwr_t pwr_of(input cbs_state_t s);
		pwr_of = '0;
		case (s)
			ST_PWR_DOWN: pwr_of = '0; // RULE12
			ST_CHG_CFG: pwr_of = '{serial_on: 1'b1, input_blocking_switch_on: 1'b1, default: 1'b0}; // RULE13
			ST_SHORT_CHG: pwr_of = '{serial_on: 1'b1, short_src_on: 1'b1,
				input_blocking_switch_on: 1'b1, default: 1'b0}; // RULE14
			ST_PWM_CHG: pwr_of = '{serial_on: 1'b1, buck_on: 1'b1,
				input_blocking_switch_on: 1'b1, default: 1'b0}; // RULE15
			ST_HIZ: pwr_of = '{serial_on: 1'b1, default: 1'b0};
			ST_BOOST: pwr_of = '{serial_on: 1'b1, boost_on: 1'b1,
				input_blocking_switch_on: 1'b1, default: 1'b0};
			default: pwr_of = '0;
		endcase
	endfunction

	wire cbs_state_t run_nxt = run_mode(hiz_req, boost_ok, boost_flt, chg_ok,
		c.rail_above_short, c.vbus_above_lockout, c.rail_above_short);
	wire pd_leave = c.vbus_above_lockout || c.rail_above_short;

	always_comb begin
		case (state_r)
			ST_PWR_DOWN: state_nxt = pd_leave ? ST_CHG_CFG : ST_PWR_DOWN; // RULE12
			ST_BOOST: state_nxt = boost_flt ? ST_CHG_CFG : run_nxt; // RULE2 RULE4
			ST_CHG_CFG, ST_SHORT_CHG, ST_PWM_CHG, ST_HIZ: state_nxt = run_nxt; // RULE13 RULE14 RULE15
			default: state_nxt = ST_PWR_DOWN;
		endcase
	end

	// sticky event bits, set wins over the clearing read
	wire [3:0] irq_evt = {state_nxt != state_r, host_exp, chg_flt_rise, boost_flt};
	wire [3:0] irq_stat_nxt = (rd_irq ? 4'h0 : irq_stat_r) | irq_evt;
	wire [3:0] fault_set = {chg_flt_rise, bat_lo, bat_hi, ovl_flt};
	wire [3:0] fault_nxt = (wr_fault ? 4'h0 : fault_r) | fault_set;

	// read mux
	wire [31:0] rd_val =
		(I_ADDR == `CBS_A_CTRL) ? {28'h0, ctrl_r} :
		(I_ADDR == `CBS_A_STATE) ? {26'h0, pulse_busy, auto32_r, ovl_lock_r, state_r} :
		(I_ADDR == `CBS_A_FAULT) ? {28'h0, fault_r} :
		(I_ADDR == `CBS_A_IRQ_STAT) ? {28'h0, irq_stat_r} :
		(I_ADDR == `CBS_A_IRQ_MASK) ? {28'h0, irq_mask_r} : 32'h0;

	// control register; a boost fault clears operation select
	always_ff @(posedge I_CLK) begin
		if (!I_RESETN)
			ctrl_r <= `CBS_CTRL_RST;
		else if (wr_ctrl)
			ctrl_r <= I_WDATA[3:0] & ~{3'h0, boost_flt}; // RULE2 RULE5
		else if (boost_flt)
			ctrl_r[`CBS_CTRL_OPSEL] <= 1'b0; // RULE2 RULE4
	end

	always_ff @(posedge I_CLK) begin
		if (!I_RESETN) begin
			state_r <= ST_PWR_DOWN;
			fault_r <= 4'h0;
			irq_stat_r <= 4'h0;
			irq_mask_r <= 4'h0;
			chg_fault_d_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			fault_r <= fault_nxt; // RULE2 RULE4
			irq_stat_r <= irq_stat_nxt;
			irq_mask_r <= wr_mask ? I_WDATA[3:0] : irq_mask_r;
			chg_fault_d_r <= c.charge_fault;
		end
	end

	// overload lockout held until the host clears the fault register
	always_ff @(posedge I_CLK) begin
		if (!I_RESETN)
			ovl_lock_r <= 1'b0;
		else if (ovl_flt)
			ovl_lock_r <= 1'b1; // RULE3
		else if (wr_fault)
			ovl_lock_r <= 1'b0; // RULE3
	end

	// overload qualification counter
	always_ff @(posedge I_CLK) begin
		if (!I_RESETN || !(boosting && c.overload))
			ovl_cnt_r <= 32'h0; // RULE1
		else if (ovl_cnt_r != OVL_CYC)
			ovl_cnt_r <= ovl_cnt_r + 32'h1; // RULE19
	end

	// crude host-presence timer; a control write shows the host is back
	always_ff @(posedge I_CLK) begin
		if (!I_RESETN) begin
			host_cnt_r <= 32'h0;
			auto32_r <= 1'b0;
		end else begin
			host_cnt_r <= (host_run && !host_exp) ? host_cnt_r + 32'h1 : 32'h0; // RULE9 RULE19
			if (host_exp)
				auto32_r <= 1'b1; // RULE10
			else if (wr_ctrl)
				auto32_r <= 1'b0;
		end
	end

	cbs_pulse #(
		.CYC(PULSE_CYC)
	) u_pulse (
		.i_clk(I_CLK),
		.i_resetn(I_RESETN),
		.i_trig(boost_flt || chg_flt_rise), // RULE7
		.o_busy(pulse_busy)
	);

	// registered outputs
	always_ff @(posedge I_CLK) begin
		if (!I_RESETN) begin
			O_PWR <= '0;
			O_POR <= 1'b0;
			O_STAT_O <= 1'b0;
			O_STAT_OE <= 1'b0;
			O_IRQ <= 1'b0;
			O_RDATA <= 32'h0;
		end else begin
			O_PWR <= pwr_of(state_nxt); // RULE12 RULE13
			O_POR <= pd_exit; // RULE12
			O_STAT_O <= 1'b0;
			O_STAT_OE <= pulse_busy || (charging && stat_en); // RULE6 RULE7 RULE17
			O_IRQ <= |(irq_stat_nxt & irq_mask_r);
			O_RDATA <= I_RD ? rd_val : 32'h0;
		end
	end

	AST_OVL_QUAL: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // RULE1
		ovl_flt |-> ($past(ovl_cnt_r) == OVL_CYC - 32'h1 || $past(ovl_cnt_r) == OVL_CYC))
		else $error("overload fault before qualification time");
	AST_OVL_SHORT: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // RULE1
		(boosting && ovl_cnt_r != OVL_CYC) |-> !ovl_flt)
		else $error("short overload produced a fault");
	AST_FAULT_ACT: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // RULE2
		boost_flt |=> (!op_sel && state_r == ST_CHG_CFG && !O_PWR.boost_on && fault_r != 4'h0))
		else $error("boost fault actions missing");
	AST_OVL_LOCK: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // RULE3
		(ovl_lock_r && !wr_fault) |=> (state_r != ST_BOOST))
		else $error("boost restarted while overload locked");
	AST_BAT_FLT: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // RULE4
		(boosting && (c.bat_above_max || c.bat_below_min)) |=> (state_r == ST_CHG_CFG) ##1 pulse_busy)
		else $error("battery fault not handled");
	AST_STAT_BOOST: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // RULE6
		(boosting && !pulse_busy) |=> !O_STAT_OE)
		else $error("status driven during clean boost");
	AST_HIZ_ENTRY: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // RULE8
		(hiz_bit && !boost_request_pin && pd_leave && state_r != ST_PWR_DOWN && !boost_flt) |=> (state_r == ST_HIZ))
		else $error("high impedance not entered");
	AST_TMR_EXP: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // RULE10
		host_exp |=> (auto32_r && host_cnt_r == 32'h0) ##1 (host_cnt_r == 32'h0))
		else $error("host timer expiry mishandled");
	AST_PD_EXIT: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // RULE12
		(state_r == ST_PWR_DOWN && pd_leave) |=> (O_POR && O_PWR.serial_on) ##1 !O_POR)
		else $error("power-down exit without reset pulse");
	AST_CFG_OFF: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // RULE13
		(state_r == ST_CHG_CFG) |-> (!O_PWR.buck_on && !O_PWR.boost_on && !O_PWR.short_src_on))
		else $error("converter on in charge configure");
	AST_SHORT_SRC: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // RULE14
		(state_r == ST_SHORT_CHG) |-> (O_PWR.short_src_on && !O_PWR.buck_on && !O_PWR.boost_on))
		else $error("short charge enables wrong");
	AST_STAT_CHG: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // RULE17
		(charging && stat_en) |=> O_STAT_OE)
		else $error("status not held low while charging");
endmodule // cbs_top
`default_nettype wire

// [cbs_top_tb_top.sv]
// self-checking bench for the charger mode and fault supervisor
`timescale 1ns/1ps
`default_nettype none
module cbs_top_tb_top;
	import cbs_pkg::*;
	localparam int OVL = 20;
	localparam int PUL = 8;
	localparam int HST = 30;
	localparam cbs_pwr_t P_PD = 5'h00;
	localparam cbs_pwr_t P_CFG = 5'h11;
	localparam cbs_pwr_t P_SHORT = 5'h15;
	localparam cbs_pwr_t P_PWM = 5'h19;
	localparam cbs_pwr_t P_HIZ = 5'h10;
	localparam cbs_pwr_t P_BST = 5'h13;
	logic I_CLK = 1'b0;
	logic I_RESETN = 1'b0;
	logic I_WR = 1'b0;
	logic I_RD = 1'b0;
	logic [7:0] I_ADDR = 8'h00;
	logic [31:0] I_WDATA = 32'h0;
	cbs_cmp_t I_CMP = 9'h000;
	logic [31:0] O_RDATA;
	cbs_pwr_t O_PWR;
	logic O_POR, O_STAT_O, O_STAT_OE, O_IRQ, pin;
	logic [31:0] rd;
	int err_total = 0, checks = 0, por_cnt = 0, pcnt, pwid, n0;
	always #12.5 I_CLK = ~I_CLK;
	always @(posedge I_CLK) if (O_POR === 1'b1) por_cnt <= por_cnt + 1;
	cbs_top #(.OVL_CYC(32'(OVL)), .PULSE_CYC(32'(PUL)), .HOST_CYC(32'(HST))) DUT (
		.I_CLK(I_CLK), .I_RESETN(I_RESETN), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR),
		.I_RD(I_RD), .O_RDATA(O_RDATA), .I_CMP(I_CMP), .O_PWR(O_PWR), .O_POR(O_POR),
		.O_STAT_O(O_STAT_O), .O_STAT_OE(O_STAT_OE), .O_IRQ(O_IRQ));
	cbs_stat_host host (.i_clk(I_CLK), .i_stat_o(O_STAT_O), .i_stat_oe(O_STAT_OE), .o_pin(pin),
		.o_cnt(pcnt), .o_width(pwid));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge I_CLK);
		I_WR <= 1'b1;
		I_ADDR <= a;
		I_WDATA <= d;
		@(posedge I_CLK);
		I_WR <= 1'b0;
	endtask
	task automatic rdr(input logic [7:0] a);
		@(posedge I_CLK);
		I_RD <= 1'b1;
		I_ADDR <= a;
		@(posedge I_CLK);
		I_RD <= 1'b0;
		#1 rd = O_RDATA;
	endtask
	task automatic setc(input cbs_cmp_t c);
		@(posedge I_CLK);
		I_CMP <= c;
	endtask
	// poll the state register, then compare state and power enables
	task automatic expect_state(input logic [2:0] s, input cbs_pwr_t p);
		int i;
		i = 0;
		rdr(8'h04);
		while (rd[2:0] !== s && i < 30) begin
			rdr(8'h04);
			i++;
		end
		chk(32'(rd[2:0]), 32'(s));
		chk(32'(O_PWR), 32'(p));
	endtask
	task automatic end_of_test;
		if (err_total == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge I_CLK);
		err_total++;
		end_of_test();
	end
	initial begin
		repeat (5) @(posedge I_CLK);
		I_RESETN <= 1'b1;
		expect_state(3'h0, P_PD);
		rdr(8'h00);
		chk(rd, 32'h0);
		rdr(8'h14);
		chk(rd, 32'h0);
		setc(9'h0E0);
		expect_state(3'h3, P_PWM);
		chk(32'(por_cnt), 32'h1);
		wr(8'h00, 32'h8);
		repeat (4) @(posedge I_CLK);
		chk(32'(O_STAT_OE), 32'h1);
		chk(32'(O_STAT_O), 32'h0);
		wr(8'h00, 32'h0);
		setc(9'h0C0);
		expect_state(3'h2, P_SHORT);
		setc(9'h0E0);
		expect_state(3'h3, P_PWM);
		wr(8'h00, 32'h4);
		expect_state(3'h1, P_CFG);
		wr(8'h00, 32'h0);
		expect_state(3'h3, P_PWM);
		wr(8'h10, 32'h1);
		wr(8'h00, 32'h1);
		expect_state(3'h5, P_BST);
		repeat (30) @(posedge I_CLK);
		chk(32'(O_STAT_OE), 32'h0);
		// overload shorter than the qualification time
		setc(9'h0E2);
		repeat (OVL - 5) @(posedge I_CLK);
		setc(9'h0E0);
		repeat (10) @(posedge I_CLK);
		rdr(8'h04);
		chk(32'(rd[2:0]), 32'h5);
		n0 = pcnt;
		setc(9'h0E2);
		expect_state(3'h3, P_PWM);
		setc(9'h0E0);
		rdr(8'h00);
		chk(rd, 32'h0);
		rdr(8'h08);
		chk(32'(rd[0]), 32'h1);
		repeat (PUL + 5) @(posedge I_CLK);
		chk(32'(pcnt), 32'(n0 + 1));
		chk(32'(pwid), 32'(PUL));
		chk(32'(O_IRQ), 32'h1);
		rdr(8'h0C);
		chk(32'(rd[0]), 32'h1);
		repeat (2) @(posedge I_CLK);
		chk(32'(O_IRQ), 32'h0);
		// request pin alone may not restart boost while the overload is latched
		setc(9'h1E0);
		repeat (20) @(posedge I_CLK);
		rdr(8'h04);
		chk(32'(rd[2:0] === 3'h5), 32'h0);
		wr(8'h08, 32'h1);
		expect_state(3'h5, P_BST);
		for (int k = 0; k < 2; k++) begin
			n0 = pcnt;
			setc(k == 0 ? 9'h1F0 : 9'h1E8);
			repeat (15) @(posedge I_CLK);
			rdr(8'h04);
			chk(32'(rd[2:0] === 3'h5), 32'h0);
			rdr(8'h08);
			chk(32'(rd[k + 1]), 32'h1);
			setc(9'h1E0);
			expect_state(3'h5, P_BST);
			repeat (PUL + 5) @(posedge I_CLK);
			chk(32'(pcnt), 32'(n0 + 1));
		end
		setc(9'h0E0);
		wr(8'h00, 32'h2);
		expect_state(3'h4, P_HIZ);
		setc(9'h1E0);
		expect_state(3'h1, P_CFG);
		setc(9'h0E0);
		expect_state(3'h4, P_HIZ);
		repeat (HST + 20) @(posedge I_CLK);
		rdr(8'h04);
		chk(32'(rd[4]), 32'h0);
		setc(9'h0E4);
		repeat (HST + 20) @(posedge I_CLK);
		rdr(8'h04);
		chk(32'(rd[4]), 32'h1);
		rdr(8'h0C);
		chk(32'(rd[2]), 32'h1);
		end_of_test();
	end
endmodule // cbs_top_tb_top
`default_nettype wire
